/* File: rtl/pdmc_pkg.sv */
package pdmc_pkg;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h00;
  localparam logic [7:0] ADDR_STOP_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_STANDBY    = 8'h08;
  localparam logic [7:0] ADDR_LOW_POWER  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0]  TIMER_MODE_RST = 8'h30;
  localparam logic [15:0] STOP_CTRL_RST  = 16'hffff;
  localparam logic [7:0]  STANDBY_RST    = 8'h00;
  localparam logic [7:0]  LOW_POWER_RST  = 8'h00;
  localparam logic [15:0] STOP_USED_MASK = 16'hfdf6;
  localparam logic [15:0] STOP_NORETAIN  = 16'h0506;
  localparam int TMR_OVF_POS    = 7;
  localparam int TMR_CLKSEL_POS = 3;
  localparam int SBY_SEL_POS    = 7;
  localparam int LP_DIRECT_TRANSFER_BIT_POS    = 7;
  localparam int LP_LOW_SPEED_ON_BIT_POS    = 6;
  localparam int SERVO_STOP_POS = 1;
  localparam logic [7:0] SBY_WMASK = 8'hf3;
  localparam logic [7:0] LP_WMASK  = 8'he3;
  localparam logic [6:0] DIV16_CNT = 7'h0f;
  localparam logic [6:0] DIV32_CNT = 7'h1f;
  localparam logic [6:0] DIV64_CNT = 7'h3f;
  typedef enum logic [2:0] {
    PDMC_HIGH   = 3'b000,
    PDMC_MEDIUM = 3'b001,
    PDMC_SLEEP  = 3'b010,
    PDMC_STBY   = 3'b011,
    PDMC_WATCH  = 3'b100,
    PDMC_SUBACT = 3'b101,
    PDMC_SUBSLP = 3'b110
  } pdmc_mode_e;
  typedef struct packed {
    logic nmi;
    logic ext_irq_line_0;
    logic ext_irq_line_1;
    logic other;
    logic masked;
  } pdmc_wake_s;
endpackage : pdmc_pkg

/* File: rtl/pdmc_top.sv */
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module pdmc_top (
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                wdt_overflow,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                sleep_req,
  input  wire logic                bus_cycle_end,
  input  wire pdmc_pkg::pdmc_wake_s wake,
  input  wire logic                timer_ovf_event,
  input  wire logic [15:0]         periph_access,
  output logic      [15:0]         module_stop,
  output logic      [15:0]         module_state_clear,
  output logic      [15:0]         periph_access_ok,
  output logic                     timer_clk_sub,
  output logic                     cpu_clk_en,
  output logic                     cpu_halt,
  output logic                     main_osc_stop,
  output logic                     io_hiz,
  output logic                     servo_clk_stop,
  output logic                     wake_irq,
  output logic [2:0]               power_mode
);
  logic [7:0]  tmr_reg, tmr_next;
  logic [15:0] stop_reg, stop_next, stop_eff_reg;
  logic [7:0]  sby_reg, sby_next;
  logic [7:0]  lp_reg, lp_next;
  logic [1:0]  div_eff_reg;
  logic [6:0]  div_cnt_reg;
  pdmc_pkg::pdmc_mode_e mode_reg, mode_next, ret_reg;
  logic        ap_wr_reg;
  logic [7:0]  ap_addr_reg;
  logic        wake_reg;

  // address phase capture
  wire ap_valid = hsel & hready & htrans[1];
  wire wr_tmr  = ap_wr_reg & (ap_addr_reg == pdmc_pkg::ADDR_TIMER_MODE);
  wire wr_stop = ap_wr_reg & (ap_addr_reg == pdmc_pkg::ADDR_STOP_CTRL);
  wire wr_sby  = ap_wr_reg & (ap_addr_reg == pdmc_pkg::ADDR_STANDBY);
  wire wr_lp   = ap_wr_reg & (ap_addr_reg == pdmc_pkg::ADDR_LOW_POWER);
  // read decode on the address phase, data stands in the data phase
  wire sel_tmr  = haddr[7:0] == pdmc_pkg::ADDR_TIMER_MODE;
  wire sel_stop = haddr[7:0] == pdmc_pkg::ADDR_STOP_CTRL;
  wire sel_sby  = haddr[7:0] == pdmc_pkg::ADDR_STANDBY;
  wire sel_lp   = haddr[7:0] == pdmc_pkg::ADDR_LOW_POWER;
  wire sel_stat = haddr[7:0] == pdmc_pkg::ADDR_STATUS;

  wire tmr_clksel = tmr_reg[pdmc_pkg::TMR_CLKSEL_POS];
  wire sby_sel    = sby_reg[pdmc_pkg::SBY_SEL_POS];
  wire low_speed_on_bit       = lp_reg[pdmc_pkg::LP_LOW_SPEED_ON_BIT_POS];
  wire direct_transfer_bit       = lp_reg[pdmc_pkg::LP_DIRECT_TRANSFER_BIT_POS];
  wire [1:0] div_sel = sby_reg[1:0];

  // overflow flag: hardware set wins over a written zero
  wire ovf_clr = wr_tmr & ~hwdata[pdmc_pkg::TMR_OVF_POS];
  wire ovf_next = timer_ovf_event |
                  (tmr_reg[pdmc_pkg::TMR_OVF_POS] & ~ovf_clr);
  always_comb begin
    tmr_next = tmr_reg;
    if (wr_tmr) begin
      tmr_next[6:0] = hwdata[6:0];
    end
    tmr_next[pdmc_pkg::TMR_OVF_POS] = ovf_next;
  end

  assign stop_next = wr_stop ?
    (hwdata[15:0] | ~pdmc_pkg::STOP_USED_MASK) : stop_reg;
  assign sby_next = wr_sby ? (hwdata[7:0] & pdmc_pkg::SBY_WMASK) : sby_reg;
  assign lp_next  = wr_lp  ? (hwdata[7:0] & pdmc_pkg::LP_WMASK)  : lp_reg;

  // wake qualification
  wire any_wake  = wake.nmi | ((wake.ext_irq_line_0 | wake.ext_irq_line_1 | wake.other) &
                   ~wake.masked);
  wire sby_wake  = wake.nmi | ((wake.ext_irq_line_0 | wake.ext_irq_line_1) &
                   ~wake.masked);

  // sleep request decode
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      pdmc_pkg::PDMC_HIGH, pdmc_pkg::PDMC_MEDIUM: begin
        if (sleep_req) begin
          if (!sby_sel && !low_speed_on_bit) begin
            mode_next = pdmc_pkg::PDMC_SLEEP;
          end else if (sby_sel && !low_speed_on_bit && !tmr_clksel) begin
            mode_next = pdmc_pkg::PDMC_STBY;
          end else if (tmr_clksel && sby_sel && !direct_transfer_bit) begin
            mode_next = pdmc_pkg::PDMC_WATCH;
          end else if (tmr_clksel && sby_sel && direct_transfer_bit) begin
            mode_next = pdmc_pkg::PDMC_SUBACT;
          end else begin
            mode_next = pdmc_pkg::PDMC_SLEEP;
          end
        end else if (bus_cycle_end) begin
          mode_next = (div_sel != 2'b00) ? pdmc_pkg::PDMC_MEDIUM :
                      pdmc_pkg::PDMC_HIGH;
        end
      end
      pdmc_pkg::PDMC_SUBACT: begin
        if (sleep_req && tmr_clksel) begin
          if (!sby_sel && low_speed_on_bit) begin
            mode_next = pdmc_pkg::PDMC_SUBSLP;
          end else if (sby_sel && !direct_transfer_bit) begin
            mode_next = pdmc_pkg::PDMC_WATCH;
          end else if (sby_sel && direct_transfer_bit && !low_speed_on_bit) begin
            mode_next = pdmc_pkg::PDMC_HIGH;
          end else begin
            mode_next = pdmc_pkg::PDMC_SUBSLP;
          end
        end
      end
      pdmc_pkg::PDMC_SLEEP: begin
        if (any_wake) begin
          mode_next = ret_reg;
        end
      end
      pdmc_pkg::PDMC_STBY: begin
        if (sby_wake) begin
          mode_next = ret_reg;
        end
      end
      pdmc_pkg::PDMC_WATCH: begin
        if (sby_wake) begin
          mode_next = low_speed_on_bit ? pdmc_pkg::PDMC_SUBACT : ret_reg;
        end
      end
      pdmc_pkg::PDMC_SUBSLP: begin
        if (any_wake) begin
          mode_next = pdmc_pkg::PDMC_SUBACT;
        end
      end
      default: mode_next = pdmc_pkg::PDMC_HIGH;
    endcase
  end

  wire enter_low = sleep_req & ((mode_reg == pdmc_pkg::PDMC_HIGH) |
                   (mode_reg == pdmc_pkg::PDMC_MEDIUM));
  wire rst_all = ~rst_b | wdt_overflow;

  // cpu clock divider
  wire [6:0] div_top = (div_eff_reg == 2'b01) ? pdmc_pkg::DIV16_CNT :
                       (div_eff_reg == 2'b10) ? pdmc_pkg::DIV32_CNT :
                       pdmc_pkg::DIV64_CNT;
  wire div_wrap = div_cnt_reg == div_top;

  always_ff @(posedge mclk) begin
    if (rst_all) begin
      tmr_reg      <= pdmc_pkg::TIMER_MODE_RST;
      stop_reg     <= pdmc_pkg::STOP_CTRL_RST;
      stop_eff_reg <= pdmc_pkg::STOP_CTRL_RST;
      sby_reg      <= pdmc_pkg::STANDBY_RST;
      lp_reg       <= pdmc_pkg::LOW_POWER_RST;
      div_eff_reg  <= 2'b00;
      div_cnt_reg  <= 7'h00;
      mode_reg     <= pdmc_pkg::PDMC_HIGH;
      ret_reg      <= pdmc_pkg::PDMC_HIGH;
      ap_wr_reg    <= 1'b0;
      ap_addr_reg  <= 8'h00;
      wake_reg     <= 1'b0;
    end else begin
      tmr_reg     <= tmr_next;
      stop_reg    <= stop_next;
      sby_reg     <= sby_next;
      lp_reg      <= lp_next;
      mode_reg    <= mode_next;
      ap_wr_reg   <= ap_valid & hwrite;
      ap_addr_reg <= ap_valid ? haddr[7:0] : ap_addr_reg;
      wake_reg    <= (mode_reg != mode_next) &
                     ((mode_reg == pdmc_pkg::PDMC_SLEEP) |
                      (mode_reg == pdmc_pkg::PDMC_STBY) |
                      (mode_reg == pdmc_pkg::PDMC_WATCH) |
                      (mode_reg == pdmc_pkg::PDMC_SUBSLP));
      if (enter_low) begin
        ret_reg <= mode_reg;
      end
      if (bus_cycle_end) begin
        stop_eff_reg <= stop_reg;
      end
      if (bus_cycle_end && mode_next != pdmc_pkg::PDMC_SLEEP &&
          mode_next != pdmc_pkg::PDMC_STBY) begin
        div_eff_reg <= div_sel;
      end
      div_cnt_reg <= (div_wrap || div_eff_reg == 2'b00) ? 7'h00 :
                     div_cnt_reg + 7'h01;
    end
  end

  // read mux of next values, so a write in its data phase is seen
  wire [31:0] rd_mux =
    sel_tmr  ? {24'h0, tmr_next} :
    sel_stop ? {16'h0, stop_next} :
    sel_sby  ? {24'h0, sby_next} :
    sel_lp   ? {24'h0, lp_next} :
    sel_stat ? {26'h0, div_eff_reg, 1'b0, mode_reg} : 32'h0;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hrdata <= 32'h0;
    end else if (ap_valid & ~hwrite) begin
      hrdata <= rd_mux;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire deep = (mode_reg == pdmc_pkg::PDMC_STBY) |
              (mode_reg == pdmc_pkg::PDMC_WATCH);
  wire low_clk = deep | (mode_reg == pdmc_pkg::PDMC_SUBACT) |
                 (mode_reg == pdmc_pkg::PDMC_SUBSLP);
  assign module_stop = stop_eff_reg |
    (low_clk ? 16'h7fff : 16'h0000);
  assign module_state_clear = stop_eff_reg &
    pdmc_pkg::STOP_NORETAIN;
  assign periph_access_ok = periph_access & ~module_stop;
  assign timer_clk_sub = tmr_clksel;
  assign cpu_clk_en = (mode_reg == pdmc_pkg::PDMC_HIGH) |
    ((mode_reg == pdmc_pkg::PDMC_MEDIUM) &
     ((div_eff_reg == 2'b00) | div_wrap));
  assign cpu_halt = (mode_reg != pdmc_pkg::PDMC_HIGH) &
    (mode_reg != pdmc_pkg::PDMC_MEDIUM) &
    (mode_reg != pdmc_pkg::PDMC_SUBACT);
  assign main_osc_stop = deep;
  assign io_hiz = deep;
  assign servo_clk_stop = (mode_reg == pdmc_pkg::PDMC_SLEEP) |
    stop_eff_reg[pdmc_pkg::SERVO_STOP_POS];
  assign wake_irq = wake_reg;
  assign power_mode = mode_reg;
endmodule : pdmc_top

/* File: sim/pdmc_cpu_model.sv */
`timescale 1ns/1ns
module pdmc_cpu_model (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  output logic             bus_cycle_end,
  output logic [15:0]      periph_access
);
  logic [1:0] cnt_reg;
  // cpu bus cycle ends every fourth clock
  always_ff @(posedge mclk) begin
    if (!rst_b)
      cnt_reg <= 2'h0;
    else
      cnt_reg <= cnt_reg + 2'h1;
  end
  assign bus_cycle_end = (cnt_reg == 2'h3);
  // modules ask for their registers in a moving pattern
  assign periph_access = {8{cnt_reg}} ^ 16'ha5c3;
endmodule : pdmc_cpu_model

/* File: sim/pdmc_top_props.sv */
`timescale 1ns/1ns
module pdmc_top_props (
  input wire logic                 mclk,
  input wire logic                 rst_b,
  input wire logic                 wdt_overflow,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire pdmc_pkg::pdmc_wake_s wake,
  input wire logic [15:0]          periph_access,
  input wire logic [15:0]          module_stop,
  input wire logic [15:0]          module_state_clear,
  input wire logic [15:0]          periph_access_ok,
  input wire logic                 cpu_clk_en,
  input wire logic                 cpu_halt,
  input wire logic                 main_osc_stop,
  input wire logic                 io_hiz,
  input wire logic                 servo_clk_stop,
  input wire logic                 wake_irq,
  input wire logic [2:0]           power_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_woken;
    power_mode inside {3'd0, 3'd1} ##[0:2] wake_irq;
  endsequence
  a_bus_okay: assert property (
    hreadyout && !hresp) else $error("bus response not okay");
  a_access_gate: assert property (
    periph_access_ok == (periph_access & ~module_stop))
    else $error("stopped module reachable");
  a_state_clear: assert property (
    module_state_clear == (module_stop & 16'h0506))
    else $error("state clear wrong");
  a_wdt_reset: assert property (
    wdt_overflow |=> power_mode == 3'd0 && module_stop == 16'hffff)
    else $error("watchdog reset ignored");
  a_high_clock: assert property (
    power_mode == 3'd0 |-> cpu_clk_en) else $error("high speed gap");
  a_medium_div: assert property (
    (power_mode == 3'd1 && cpu_clk_en) |=>
      (!cpu_clk_en || power_mode != 3'd1) [*8])
    else $error("medium clock too fast");
  a_sleep_outs: assert property (
    power_mode == 3'd2 |-> cpu_halt && !main_osc_stop && servo_clk_stop)
    else $error("sleep outputs wrong");
  a_stby_outs: assert property (
    power_mode == 3'd3 |-> cpu_halt && main_osc_stop && io_hiz)
    else $error("standby outputs wrong");
  a_stby_hold: assert property (
    (power_mode == 3'd3 && !wake.nmi && !wake.ext_irq_line_0 && !wake.ext_irq_line_1
      && !wdt_overflow) |=> power_mode == 3'd3)
    else $error("standby left wrongly");
  a_sleep_hold: assert property (
    (power_mode == 3'd2 && wake.masked && !wake.nmi && !wdt_overflow)
      |=> power_mode == 3'd2) else $error("masked wake ended sleep");
  a_sleep_wake: assert property (
    (power_mode == 3'd2 && wake.other && !wake.masked && !wdt_overflow)
      |=> s_woken) else $error("sleep not ended");
endmodule : pdmc_top_props
bind pdmc_top pdmc_top_props u_props (.mclk, .rst_b, .wdt_overflow,
  .hreadyout, .hresp, .wake, .periph_access, .module_stop,
  .module_state_clear, .periph_access_ok, .cpu_clk_en, .cpu_halt,
  .main_osc_stop, .io_hiz, .servo_clk_stop, .wake_irq, .power_mode);

/* File: sim/pdmc_top_tb.sv */
`timescale 1ns/1ns
module pdmc_top_tb;
  logic                 mclk, rst_b, wdt_overflow, hsel, hwrite, hready;
  logic                 sleep_req, timer_ovf_event, hreadyout, cpu_clk_en;
  logic                 bus_cycle_end, timer_clk_sub;
  logic [31:0]          haddr, hwdata, hrdata;
  logic [1:0]           htrans;
  logic [2:0]           hsize, power_mode;
  logic [15:0]          periph_access, module_stop, module_state_clear;
  pdmc_pkg::pdmc_wake_s wake;
  int                   num_errors, num_checks, p;
  pdmc_top u_dut (.mclk, .rst_b, .wdt_overflow, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp(),
    .sleep_req, .bus_cycle_end, .wake, .timer_ovf_event, .periph_access,
    .module_stop, .module_state_clear, .periph_access_ok(),
    .timer_clk_sub, .cpu_clk_en, .cpu_halt(), .main_osc_stop(),
    .io_hiz(), .servo_clk_stop(), .wake_irq(), .power_mode);
  pdmc_cpu_model u_cpu (.mclk, .rst_b, .bus_cycle_end, .periph_access);
  assign hready = hreadyout;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic till(input int which);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((which ? bus_cycle_end : hreadyout) !== 1'b1 && n < 99);
    if (n >= 99) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : till
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    till(0);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    till(0);
    q = hrdata;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk("register", q, e);
  endtask : rc
  task automatic pulse(input int k, input pdmc_pkg::pdmc_wake_s v);
    @(posedge mclk);
    if (k == 0) sleep_req <= 1'b1;
    if (k == 1) wake <= v;
    if (k == 2) wdt_overflow <= 1'b1;
    if (k == 3) timer_ovf_event <= 1'b1;
    @(posedge mclk);
    {sleep_req, wdt_overflow, timer_ovf_event} <= 3'h0;
    wake <= '0;
    #1;
  endtask : pulse
  task automatic cm(input logic [31:0] e);
    chk("mode", 32'(power_mode), e);
  endtask : cm
  initial begin
    {rst_b, wdt_overflow, hsel, hwrite, sleep_req, timer_ovf_event} = '0;
    {haddr, hwdata, htrans, wake, num_errors, num_checks} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rc(pdmc_pkg::ADDR_TIMER_MODE, 32'h30);
    rc(pdmc_pkg::ADDR_STOP_CTRL, 32'hffff);
    rc(8'h14, 32'h0);
    pulse(3, '0);
    rc(pdmc_pkg::ADDR_TIMER_MODE, 32'hb0);
    wr(pdmc_pkg::ADDR_TIMER_MODE, 32'hb8);
    rc(pdmc_pkg::ADDR_TIMER_MODE, 32'hb8);
    chk("clksel", 32'(timer_clk_sub), 32'h1);
    wr(pdmc_pkg::ADDR_TIMER_MODE, 32'h30);
    rc(pdmc_pkg::ADDR_TIMER_MODE, 32'h30);
    chk("clksel", 32'(timer_clk_sub), 32'h0);
    wr(pdmc_pkg::ADDR_STOP_CTRL, 32'h0);
    till(1);
    #1;
    chk("stop", 32'(module_stop & 16'hfdf6), 32'h0);
    rc(pdmc_pkg::ADDR_STOP_CTRL, 32'h0209);
    wr(pdmc_pkg::ADDR_STOP_CTRL, 32'hffff);
    till(1);
    #1;
    chk("stop", 32'(module_stop), 32'hffff);
    chk("clear", 32'(module_state_clear), 32'h0506);
    for (int i = 1; i < 4; i++) begin
      wr(pdmc_pkg::ADDR_STANDBY, 32'(i));
      till(1);
      #1;
      cm(32'h1);
      repeat (70) @(posedge mclk);
      while (cpu_clk_en !== 1'b1 && p < 99) begin
        @(posedge mclk);
        p++;
      end
      p = 0;
      do begin
        @(posedge mclk);
        p++;
      end while (cpu_clk_en !== 1'b1 && p < 99);
      chk("divide", 32'(p), 32'h8 << i);
    end
    wr(pdmc_pkg::ADDR_STANDBY, 32'h0);
    till(1);
    #1;
    cm(32'h0);
    wr(pdmc_pkg::ADDR_STANDBY, 32'h1);
    till(1);
    pulse(0, '0);
    cm(32'h2);
    pulse(1, 5'b00011);
    cm(32'h2);
    pulse(1, 5'b00010);
    cm(32'h1);
    wr(pdmc_pkg::ADDR_STANDBY, 32'h81);
    pulse(0, '0);
    cm(32'h3);
    pulse(1, 5'b00010);
    cm(32'h3);
    pulse(1, 5'b01000);
    cm(32'h1);
    wr(pdmc_pkg::ADDR_TIMER_MODE, 32'h38);
    pulse(0, '0);
    cm(32'h4);
    pulse(2, '0);
    cm(32'h0);
    rc(pdmc_pkg::ADDR_STANDBY, 32'h0);
    tally_and_finish();
  end
endmodule : pdmc_top_tb
